// ===== adctc_defines.vh
// constants for the converter trigger and conversion-time control block
// assumes a 200 MHz system clock and a 32-bit ahb-lite register bus
`ifndef ADCTC_DEFINES_VH
`define ADCTC_DEFINES_VH

// -----------------------------------------------------------------
// register map
// -----------------------------------------------------------------
`define ADCTC_CTRL_OFFSET    8'h00
`define ADCTC_STATUS_OFFSET  8'h04
`define ADCTC_START_OFFSET   8'h08

// -----------------------------------------------------------------
// control register fields
// -----------------------------------------------------------------
`define ADCTC_TRG_HI         7
`define ADCTC_TRG_LO         6
`define ADCTC_CKS_HI         3
`define ADCTC_CKS_LO         2
`define ADCTC_RSVD_MASK      8'h33
`define ADCTC_CTRL_RESET     8'h33

// -----------------------------------------------------------------
// trigger sources
// -----------------------------------------------------------------
`define ADCTC_SRC_SOFT       2'h0
`define ADCTC_SRC_PULSE      2'h1
`define ADCTC_SRC_TMR8       2'h2
`define ADCTC_SRC_PIN        2'h3

// -----------------------------------------------------------------
// conversion times in states (system clock cycles)
// -----------------------------------------------------------------
`define ADCTC_TIME_0         10'h212
`define ADCTC_TIME_1         10'h10A
`define ADCTC_TIME_2         10'h086
`define ADCTC_TIME_3         10'h044

`endif

// ===== adctc_sync.v
// two-flop synchroniser followed by a rising edge detector
// assumes an asynchronous input and one clock domain
`timescale 1ns/1ps
`default_nettype none

module adctc_sync (
  input  wire hclk,     // system clock
  input  wire hresetn,  // async reset, active low
  input  wire din,      // asynchronous level
  output reg  rise      // one-cycle pulse on a rising edge
);

  reg meta;   // first stage, read only by stage two
  reg stab;   // second stage
  reg stab_d; // delayed copy for edge detection

  // -----------------------------------------------------------------
  // synchroniser and edge
  // -----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta   <= 1'b0;
      stab   <= 1'b0;
      stab_d <= 1'b0;
      rise   <= 1'b0;
    end else begin
      meta   <= din;
      stab   <= meta;
      stab_d <= stab;
      rise   <= stab & ~stab_d;
    end
  end

endmodule // adctc_sync

`default_nettype wire

// ===== adctc_top.v
// trigger source and conversion time control for the a/d converter
// assumes a single ahb-lite master and async trigger inputs
`timescale 1ns/1ps
`default_nettype none
`include "adctc_defines.vh"

module adctc_top (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        pulse_timer_unit_trigger,
  input  wire        timer8_trigger,
  input  wire        external_conversion_trigger_pin,
  output reg         conversion_running,
  output reg         conversion_start,
  output reg  [1:0]  conversion_time_select
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  reg  [1:0] trigger_source_select; // start source field
  reg  [9:0] conv_count;            // states left in a conversion
  reg        wr_pend;               // write data phase pending
  reg  [7:0] wr_addr;               // latched write address
  wire       pulse_rise;            // synchronised trigger edges
  wire       tmr8_rise;
  wire       pin_rise;
  wire       addr_valid;            // accepted address phase
  wire [7:0] ctrl_read;             // control register image
  reg        hw_trigger;            // selected trigger fired
  reg  [9:0] conv_limit;            // time for current setting

  assign addr_valid = hsel & htrans[1] & hready;
  // reserved bits always read as one
  assign ctrl_read = {trigger_source_select, 2'b11,
                      conversion_time_select, 2'b11};

  // -----------------------------------------------------------------
  // trigger inputs cross from outside the clock domain
  // -----------------------------------------------------------------
  adctc_sync u_sync_pulse (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (pulse_timer_unit_trigger),
    .rise    (pulse_rise)
  );

  adctc_sync u_sync_tmr8 (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (timer8_trigger),
    .rise    (tmr8_rise)
  );

  adctc_sync u_sync_pin (
    .hclk    (hclk),
    .hresetn (hresetn),
    .din     (external_conversion_trigger_pin),
    .rise    (pin_rise)
  );

  // -----------------------------------------------------------------
  // source selection and time lookup
  // -----------------------------------------------------------------
  always @* begin
    case (trigger_source_select)
      `ADCTC_SRC_PULSE: hw_trigger = pulse_rise;
      `ADCTC_SRC_TMR8:  hw_trigger = tmr8_rise;
      `ADCTC_SRC_PIN:   hw_trigger = pin_rise;
      default:          hw_trigger = 1'b0; // software only
    endcase
    case (conversion_time_select)
      2'h0:    conv_limit = `ADCTC_TIME_0;
      2'h1:    conv_limit = `ADCTC_TIME_1;
      2'h2:    conv_limit = `ADCTC_TIME_2;
      default: conv_limit = `ADCTC_TIME_3;
    endcase
  end

  // -----------------------------------------------------------------
  // bus slave: zero wait states, always okay
  // -----------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend <= addr_valid & hwrite;
      if (addr_valid) begin
        wr_addr <= haddr[7:0];
      end
      // read data is registered so it stands in the data phase
      if (addr_valid & ~hwrite) begin
        case (haddr[7:0])
          `ADCTC_CTRL_OFFSET:   hrdata <= {24'h000000, ctrl_read};
          `ADCTC_STATUS_OFFSET: hrdata <= {31'h00000000, conversion_running};
          default:              hrdata <= 32'h00000000; // unmapped reads zero
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // control fields and conversion sequencer
  // -----------------------------------------------------------------
  // fields are written whenever software asks; keeping them still
  // during a conversion is up to software the counter
  // keeps the limit it latched nonetheless
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trigger_source_select  <= 2'h0;
      conversion_time_select <= 2'h0;
      conversion_running     <= 1'b0;
      conversion_start       <= 1'b0;
      conv_count             <= 10'h000;
    end else begin
      conversion_start <= 1'b0;
      if (wr_pend && wr_addr == `ADCTC_CTRL_OFFSET) begin
        // reserved positions are dropped on write
        trigger_source_select  <= hwdata[`ADCTC_TRG_HI:`ADCTC_TRG_LO];
        conversion_time_select <= hwdata[`ADCTC_CKS_HI:`ADCTC_CKS_LO];
      end
      if (conversion_running) begin
        // count down the selected maximum time
        if (conv_count == 10'h001) begin
          conversion_running <= 1'b0;
        end
        conv_count <= conv_count - 10'h001;
      end else if (hw_trigger ||
                   (wr_pend && wr_addr == `ADCTC_START_OFFSET && hwdata[0] &&
                    trigger_source_select == `ADCTC_SRC_SOFT)) begin
        conversion_running <= 1'b1;
        conversion_start   <= 1'b1;
        conv_count         <= conv_limit;
      end
    end
  end

endmodule // adctc_top

`default_nettype wire

// ===== adctc_trig_model.sv
// trigger sources: pulse timer, 8-bit timer, pin
// assumes one clock; lines idle low between pulses
`timescale 1ns/1ps
`default_nettype none
module adctc_trig_model (
  input  wire logic       hclk,
  output var  logic [2:0] trig  // pulse timer, 8-bit timer, pin
);
  logic [2:0] age = 3'h0;  // cycles a pulse has stood
  initial trig = 3'h0;
  // four cycles high, so the synchroniser cannot miss it
  always @(posedge hclk) begin
    age <= (trig != 3'h0) ? age + 3'h1 : 3'h0;
    if (age == 3'h3) trig <= 3'h0;
  end
  task automatic fire(input int k);
    @(posedge hclk);
    trig[k] <= 1'b1;
  endtask
endmodule  // adctc_trig_model
`default_nettype wire

// ===== adctc_assertions.sv
// checker bound to adctc_top
// assumes one clock and async active-low reset
`timescale 1ns/1ps
`default_nettype none
module adctc_assertions (
  input wire logic        hclk, hresetn, hsel, hwrite, hready,
  input wire logic [31:0] haddr, hwdata, hrdata,
  input wire logic [1:0]  htrans, conversion_time_select,
  input wire logic        external_conversion_trigger_pin, conversion_running, conversion_start
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic       wr;   // control write in data phase
  logic [1:0] src;  // source set by software
  logic [1:0] sel;  // time code at start
  logic [9:0] cnt;  // cycles run so far
  wire        acc = hsel && htrans[1] && hready && haddr[7:0] == 8'h00;
  wire  [9:0] tmax = sel[1] ? (sel[0] ? 10'h044 : 10'h086) : (sel[0] ? 10'h10A : 10'h212);
  // shadow of software state; a run keeps the time code it began with
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {wr, src, sel, cnt} <= 15'h0000;
    end else begin
      wr  <= acc && hwrite;
      src <= wr ? hwdata[7:6] : src;
      sel <= conversion_start ? conversion_time_select : sel;
      cnt <= conversion_running ? cnt + 10'h001 : 10'h000;
    end
  end
  AST_RSVD: assert property ($past(acc && !hwrite) |->
    hrdata[5:4] == 2'h3 && hrdata[1:0] == 2'h3) else $error("reserved bits not one");
  AST_RST: assert property ($rose(hresetn) |->
    conversion_time_select == 2'h0 && !conversion_running) else $error("bad reset state");
  AST_GO: assert property (conversion_start |->
    !$past(conversion_running) ##1 conversion_running) else $error("start not from idle");
  AST_TIME: assert property ($fell(conversion_running) |-> cnt == tmax)
    else $error("run length wrong");
  AST_SRC: assert property ($rose(external_conversion_trigger_pin) && src != 2'h3
    |=> !conversion_start [*8]) else $error("unselected pin started");
endmodule  // adctc_assertions
bind adctc_top adctc_assertions i_adctc_assertions (.*);
`default_nettype wire

// ===== test_adctc_top.sv
// bench: ahb-lite tasks, trigger model, compares
// assumes the bound checker
`timescale 1ns/1ps
`default_nettype none
module test_adctc_top;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [15:0] lf = 16'h3DD4;  // lfsr state
  wire  [31:0] hrdata;
  wire         hready, run, start, resp;
  wire  [1:0]  tsel;
  wire  [2:0]  trig;
  int          bad_count = 0, total_checks = 0, n;
  int          tm [4] = '{530, 266, 134, 68};  // run length per time code
  always #2.5 hclk = ~hclk;
  adctc_top i_adctc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(resp), .pulse_timer_unit_trigger(trig[0]),
    .timer8_trigger(trig[1]), .external_conversion_trigger_pin(trig[2]),
    .conversion_running(run), .conversion_start(start), .conversion_time_select(tsel));
  adctc_trig_model i_adctc_trig_model (.hclk(hclk), .trig(trig));
  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // one word transfer; each phase held until ready is seen
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, hwrite, haddr, htrans} <= {1'b1, w, a, 2'h2};
    do @(posedge hclk); while (hready !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic give_verdict;
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    give_verdict;
  end
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    #1 chk(32'h0, {28'h0, run, start, tsel});
    bus(1'b0, 32'h0, 32'h0);
    chk(32'h33, rd);
    chk(32'h0, {31'h0, resp});
    bus(1'b0, 32'h4, 32'h0);
    chk(32'h0, rd);
    bus(1'b0, 32'h10, 32'h0);
    chk(32'h0, rd);
    for (int s = 0; s < 4; s++) begin
      lf = nx(lf);
      bus(1'b1, 32'h0, ({lf, lf} & 32'hFFFFFF33) | 32'(s * 68));
      #1 chk(32'(s), {30'h0, tsel});
      bus(1'b0, 32'h0, 32'h0);
      chk(32'h33 | 32'(s * 68), rd);
      for (int t = 0; t < 4; t++) begin
        if (t == 0) bus(1'b1, 32'h8, 32'h1);
        else i_adctc_trig_model.fire(t - 1);
        #1 n = 0;
        while (n < 12 && start !== 1'b1) begin
          @(posedge hclk);
          #1 n++;
        end
        chk(32'(t == s), {31'h0, start});
        for (n = 0; run === 1'b1 && n < 1000; n++) #5;
        if (t == s) chk(32'(tm[s]), 32'(n));
      end
    end
    give_verdict;
  end
endmodule  // test_adctc_top
`default_nettype wire
